// ===== evc_defines.vh
// Contract
// - Minimum pressure/altitude held in three bytes, MSB first.
// - Maximum pressure/altitude held in three bytes, MSB first.
// - Altitude form: signed, 4-bit fraction in low bits.
// - Pressure form: unsigned, 18 integer, 2 fraction bits.
// - Temperature extremes: signed 12-bit, 4-bit fraction.
// - Minimum temperature in two bytes, upper first.
// - Maximum temperature in two bytes, upper first.
// - Extremes reset zero, host-clearable, low nibble read-only.
// - Control register layout and zero reset value.
// - Altitude bit selects barometer or altimeter form.
// - Oversampling ratio is two to the code.
// - Software reset: standby, reload defaults, bit self-clears.
// - One-shot in standby measures once, then self-clears.
`ifndef EVC_DEFINES_VH
`define EVC_DEFINES_VH
`define EVC_ADDR_PMIN_H 8'h1c
`define EVC_ADDR_PMIN_M 8'h1d
`define EVC_ADDR_PMIN_L 8'h1e
`define EVC_ADDR_TMIN_H 8'h1f
`define EVC_ADDR_TMIN_L 8'h20
`define EVC_ADDR_PMAX_H 8'h21
`define EVC_ADDR_PMAX_M 8'h22
`define EVC_ADDR_PMAX_L 8'h23
`define EVC_ADDR_TMAX_H 8'h24
`define EVC_ADDR_TMAX_L 8'h25
`define EVC_ADDR_CTRL 8'h26
`define EVC_CTRL_RESET 8'h00
`define EVC_BIT_ALT 7
`define EVC_BIT_OS_HI 5
`define EVC_BIT_OS_LO 3
`define EVC_BIT_RST 2
`define EVC_BIT_OST 1
`define EVC_BIT_STANDBY_ACTIVE_SELECT 0
`define EVC_LOW_MASK 8'hf0
`define EVC_BOOT_CYCLES 4'h8
`endif

// ===== evc_host_model.sv
`timescale 1ns/1ns
module evc_host_model (
    input logic clk,
    output logic reg_wr = 0, reg_rd = 0,
    output logic [7:0] reg_addr = 0, reg_wdata = 0,
    input logic [7:0] reg_rdata
);
    // Released write data is inverted so a stale byte is never mistaken for a live one.
    task wr(logic [7:0] a, v);
        @(posedge clk);
        {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
        @(posedge clk);
        {reg_wdata, reg_wr} <= {~v, 1'b0};
    endtask
    task rd(logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk);
        reg_rd <= 0;
        #1 v = reg_rdata;
    endtask
endmodule // evc_host_model

// ===== evc_regs.v
`timescale 1ns/1ns
`include "evc_defines.vh"
// Extreme-value capture registers and main control register.
// The serial bus engine outside presents byte writes and reads by address.
module evc_regs #(
    parameter BOOT_CYCLES = `EVC_BOOT_CYCLES
) (
    // Clock and reset
    input wire clk,
    input wire rst_b,
    // Register port from the serial bus engine
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // Measurement engine results
    input wire meas_done,
    input wire [19:0] meas_press_alt,
    input wire [11:0] meas_temp,
    // Measurement engine control
    output wire meas_start,
    output wire active_mode,
    output wire altitude_mode_select,
    output wire [2:0] oversample_code,
    output wire [7:0] oversample_ratio,
    // Serial engine reset
    output wire bus_reset
);
    // Reset is released through two flops so that no register leaves reset on a metastable edge.
    reg rst_s1_r;
    reg rst_s2_r;
    wire rst_n = rst_s2_r;

    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    reg [19:0] pmin_r;
    reg [19:0] pmax_r;
    reg [11:0] tmin_r;
    reg [11:0] tmax_r;
    reg alt_r;
    reg [2:0] os_r;
    reg ost_r;
    reg standby_active_select_r;
    reg boot_r;
    reg [3:0] boot_cnt_r;
    reg ost_pend_r;

    // Signed compare in altitude form, unsigned in pressure form.
    function less20;
        input [19:0] a;
        input [19:0] b;
        input signed_cmp;
        begin
            if (signed_cmp)
                less20 = $signed(a) < $signed(b);
            else
                less20 = a < b;
        end
    endfunction

    // Temperature extremes are always signed.
    function less12;
        input [11:0] a;
        input [11:0] b;
        begin
            less12 = $signed(a) < $signed(b);
        end
    endfunction

    // Low bytes carry four value bits on top; the reserved nibble always reads zero.
    function [7:0] low_byte;
        input [3:0] frac;
        begin
            low_byte = {frac, 4'h0};
        end
    endfunction

    assign altitude_mode_select = alt_r;
    assign oversample_code = os_r;
    assign oversample_ratio = 8'h01 << os_r;
    assign active_mode = standby_active_select_r;
    assign bus_reset = boot_r;
    // A fresh one-shot request is passed out once as a start pulse.
    assign meas_start = ost_pend_r;

    wire wr_ctrl = reg_wr && reg_addr == `EVC_ADDR_CTRL;
    // Results are kept at full precision; their fraction bits land on top of the low bytes.
    wire [19:0] pnew = meas_press_alt;
    wire [11:0] tnew = meas_temp;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pmin_r <= 20'h0_0000;
            pmax_r <= 20'h0_0000;
            tmin_r <= 12'h000;
            tmax_r <= 12'h000;
            alt_r <= 1'b0;
            os_r <= 3'h0;
            ost_r <= 1'b0;
            standby_active_select_r <= 1'b0;
            boot_r <= 1'b0;
            boot_cnt_r <= 4'h0;
            ost_pend_r <= 1'b0;
        end
        else if (boot_r)
        begin
            // Reboot: device already dropped to standby, reload defaults.
            // Host writes are refused until the count runs out.
            pmin_r <= 20'h0_0000;
            pmax_r <= 20'h0_0000;
            tmin_r <= 12'h000;
            tmax_r <= 12'h000;
            alt_r <= 1'b0;
            os_r <= 3'h0;
            ost_r <= 1'b0;
            standby_active_select_r <= 1'b0;
            ost_pend_r <= 1'b0;
            boot_cnt_r <= boot_cnt_r + 4'h1;
            if (boot_cnt_r == BOOT_CYCLES - 4'h1)
                boot_r <= 1'b0;
        end
        else
        begin
            ost_pend_r <= 1'b0;
            // Measurement result updates extremes; host write below wins.
            if (meas_done)
            begin
                // The mode bit is read live, so extremes stored in the other form compare
                // as mixed units; the host should clear them after switching modes.
                if (less20(pnew, pmin_r, alt_r))
                    pmin_r <= pnew;
                if (less20(pmax_r, pnew, alt_r))
                    pmax_r <= pnew;
                if (less12(tnew, tmin_r))
                    tmin_r <= tnew;
                if (less12(tmax_r, tnew))
                    tmax_r <= tnew;
                if (!standby_active_select_r)
                    ost_r <= 1'b0;
            end
            if (reg_wr)
            begin
                case (reg_addr)
                    `EVC_ADDR_PMIN_H: pmin_r[19:12] <= reg_wdata;
                    `EVC_ADDR_PMIN_M: pmin_r[11:4] <= reg_wdata;
                    `EVC_ADDR_PMIN_L: pmin_r[3:0] <= reg_wdata[7:4];
                    `EVC_ADDR_TMIN_H: tmin_r[11:4] <= reg_wdata;
                    `EVC_ADDR_TMIN_L: tmin_r[3:0] <= reg_wdata[7:4];
                    `EVC_ADDR_PMAX_H: pmax_r[19:12] <= reg_wdata;
                    `EVC_ADDR_PMAX_M: pmax_r[11:4] <= reg_wdata;
                    `EVC_ADDR_PMAX_L: pmax_r[3:0] <= reg_wdata[7:4];
                    `EVC_ADDR_TMAX_H: tmax_r[11:4] <= reg_wdata;
                    `EVC_ADDR_TMAX_L: tmax_r[3:0] <= reg_wdata[7:4];
                    default: ;
                endcase
            end
            if (wr_ctrl)
            begin
                if (reg_wdata[`EVC_BIT_RST])
                begin
                    standby_active_select_r <= 1'b0;
                    boot_r <= 1'b1;
                    boot_cnt_r <= 4'h0;
                end
                else
                begin
                    // Mode fields are taken as written; the host must be in standby.
                    alt_r <= reg_wdata[`EVC_BIT_ALT];
                    os_r <= reg_wdata[`EVC_BIT_OS_HI:`EVC_BIT_OS_LO];
                    standby_active_select_r <= reg_wdata[`EVC_BIT_STANDBY_ACTIVE_SELECT];
                    ost_r <= reg_wdata[`EVC_BIT_OST];
                    ost_pend_r <= reg_wdata[`EVC_BIT_OST] && !ost_r;
                end
            end
        end
    end

    reg [7:0] rdata_nxt;

    // Read decode is combinational; reserved and reset bits read zero.
    always @*
    begin
        case (reg_addr)
            `EVC_ADDR_PMIN_H: rdata_nxt = pmin_r[19:12];
            `EVC_ADDR_PMIN_M: rdata_nxt = pmin_r[11:4];
            `EVC_ADDR_PMIN_L: rdata_nxt = low_byte(pmin_r[3:0]);
            `EVC_ADDR_TMIN_H: rdata_nxt = tmin_r[11:4];
            `EVC_ADDR_TMIN_L: rdata_nxt = low_byte(tmin_r[3:0]);
            `EVC_ADDR_PMAX_H: rdata_nxt = pmax_r[19:12];
            `EVC_ADDR_PMAX_M: rdata_nxt = pmax_r[11:4];
            `EVC_ADDR_PMAX_L: rdata_nxt = low_byte(pmax_r[3:0]);
            `EVC_ADDR_TMAX_H: rdata_nxt = tmax_r[11:4];
            `EVC_ADDR_TMAX_L: rdata_nxt = low_byte(tmax_r[3:0]);
            `EVC_ADDR_CTRL: rdata_nxt = {alt_r, 1'b0, os_r, 1'b0, ost_r, standby_active_select_r};
            default: rdata_nxt = 8'h00;
        endcase
    end

    // The returned byte is registered and holds until the next read strobe.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= rdata_nxt;
    end
endmodule // evc_regs

// ===== evc_regs_monitor.sv
`timescale 1ns/1ns
module evc_regs_monitor #(parameter BOOT_CYCLES = 4'h8) (
    // Clock and reset
    input logic clk,
    input logic rst_b,
    // Register port
    input logic reg_wr,
    input logic reg_rd,
    input logic [7:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic [7:0] reg_rdata,
    // Control outputs
    input logic meas_start,
    input logic active_mode,
    input logic bus_reset,
    input logic altitude_mode_select,
    input logic [2:0] oversample_code,
    input logic [7:0] oversample_ratio
);
    localparam int BC = BOOT_CYCLES - 1;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire cw = reg_wr && reg_addr == 8'h26 && !bus_reset;
    property p_nib; reg_rd && reg_addr inside {8'h1e, 8'h20, 8'h23, 8'h25} |=> reg_rdata[3:0] == 0; endproperty
    a_nib: assert property (p_nib) else $error("low nibble set");
    property p_rsv; reg_rd && reg_addr == 8'h26 |=> !reg_rdata[6] && !reg_rdata[2]; endproperty
    a_rsv: assert property (p_rsv) else $error("control reads one");
    // The synchroniser holds the fields in reset for two edges, so the ratio is judged later.
    property p_os; $past(rst_b, 3) |-> oversample_ratio == 8'h01 << oversample_code; endproperty
    a_os: assert property (p_os) else $error("ratio wrong");
    property p_st; meas_start |-> $past(cw && reg_wdata[1]) ##1 !meas_start; endproperty
    a_st: assert property (p_st) else $error("bad start pulse");
    property p_ctl; cw && !reg_wdata[2] |=> {altitude_mode_select, oversample_code, active_mode} ==
        $past({reg_wdata[7], reg_wdata[5:3], reg_wdata[0]}); endproperty
    a_ctl: assert property (p_ctl) else $error("control fields");
    property p_boot; cw && reg_wdata[2] |=> bus_reset && !active_mode; endproperty
    a_boot: assert property (p_boot) else $error("no reboot");
    property p_len; $rose(bus_reset) |-> ##BC bus_reset ##1 !bus_reset; endproperty
    a_len: assert property (p_len) else $error("reboot length");
    property p_def; $fell(bus_reset) |-> !active_mode && !altitude_mode_select && !oversample_code; endproperty
    a_def: assert property (p_def) else $error("defaults");
    c_st: cover property (meas_start);
    c_boot: cover property ($fell(bus_reset));
    c_act: cover property (cw && reg_wdata[0]);
endmodule // evc_regs_monitor
bind evc_regs evc_regs_monitor #(.BOOT_CYCLES(BOOT_CYCLES)) mon (.*);

// ===== tb_extreme_value_capture_regs.sv
`timescale 1ns/1ns
`include "evc_defines.vh"
module tb_extreme_value_capture_regs;
    logic clk = 0, rst_b = 0, meas_done = 0, reg_wr, reg_rd, meas_start, active_mode, bus_reset;
    logic altitude_mode_select;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, oversample_ratio, d, x;
    logic [19:0] meas_press_alt = 0;
    logic [11:0] meas_temp = 0;
    logic [2:0] oversample_code;
    int failures = 0, cmp_count = 0;
    always #10 clk = ~clk;
    evc_regs dut (.*);
    evc_host_model host (.*);
    task rv(logic [7:0] a, int n, logic [87:0] e);
        for (int i = 0; i < n; i++)
        begin
            host.rd(a + i[7:0], d);
            x = e[8 * (n - 1 - i) +: 8];
            cmp_count++;
            if (d !== x)
                $display("[FAIL] rdata %h expected %h seen %h", a + i[7:0], x, d);
            failures += int'(d !== x);
        end
    endtask
    task chk(string n, logic [7:0] e, logic [7:0] s);
        cmp_count++;
        if (s !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", n, e, s);
            failures++;
        end
    endtask
    task meas(logic [19:0] p, logic [11:0] t);
        @(posedge clk);
        {meas_done, meas_press_alt, meas_temp} <= {1'b1, p, t};
        @(posedge clk);
        meas_done <= 0;
    endtask
    task complete_run;
        $display("%0d failures in %0d checks", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task t_capture;
        rv(8'h1c, 11, 0);
        meas(20'h1_2345, 12'h1a7);
        rv(8'h1c, 10, 80'h0000_0000_0012_3450_1a70);
        host.wr(8'h1c, 8'hff);
        meas(20'h8_0000, 12'h1a7);
        rv(8'h1c, 8, 64'h8000_0000_0080_0000);
        host.wr(8'h26, 8'h80);
        #1 chk("altitude_mode_select", 8'h01, {7'h00, altitude_mode_select});
        for (int i = 0; i < 8; i++)
            host.wr(8'h1c + i[7:0], 8'h0f);
        meas(20'hf_ff00, 12'hf80);
        rv(8'h1c, 8, 64'hfff0_00f8_000f_0f00);
    endtask
    task t_control;
        int n;
        for (int c = 0; c < 8; c++)
        begin
            host.wr(8'h26, 8'h40 | c[7:0] << 3);
            #1 chk("oversample_ratio", 8'h01 << c, oversample_ratio);
            chk("oversample_code", {5'h00, c[2:0]}, {5'h00, oversample_code});
            rv(8'h26, 1, {2'b00, c[2:0], 3'b000});
        end
        host.wr(8'h26, 8'h02);
        #1 chk("meas_start", 8'h01, {7'h00, meas_start});
        meas(20'h0_0000, 12'h000);
        rv(8'h26, 1, 8'h00);
        host.wr(8'h26, 8'h01);
        #1 chk("active_mode", 8'h01, {7'h00, active_mode});
        host.wr(8'h26, 8'h03);
        #1 chk("meas_start", 8'h01, {7'h00, meas_start});
        meas(20'h0_0000, 12'h000);
        rv(8'h26, 1, 8'h03);
        host.wr(8'h26, 8'h07);
        #1 chk("bus_reset", 8'h01, {7'h00, bus_reset});
        chk("active_mode", 8'h00, {7'h00, active_mode});
        n = 0;
        while (bus_reset !== 1'b0 && n < 20)
        begin
            @(posedge clk);
            #1 n++;
        end
        chk("reboot cycles", {4'h0, `EVC_BOOT_CYCLES}, n[7:0]);
        rv(8'h1c, 11, 0);
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        rst_b <= 1;
        repeat (4) @(posedge clk);
        t_capture;
        t_control;
        complete_run;
    end
    initial
    begin
        #50000 failures++;
        complete_run;
    end
endmodule // tb_extreme_value_capture_regs
